// *** vtc_consts.svh ***
// vtc_consts.svh: offsets, field positions, reset values and sizes
// for the vlan tag classifier; included by the design files.
`ifndef VTC_CONSTS_SVH
`define VTC_CONSTS_SVH

// sizes
`define VTC_NPORTS        8
`define VTC_VLAN_DEPTH    4096
`define VTC_MAC_ENTRIES   16
`define VTC_ROUTES        16
`define VTC_VIFS          16
`define VTC_MAX_VLANS     9'h0ff
`define VTC_LAST_VID      12'hfff

// reset values and tag format
`define VTC_RST_PORT_DEFAULT_VLAN_ID      12'h001
`define VTC_RST_MEMB      16'hffff
`define VTC_TPID          16'h8100

// register byte offsets
`define VTC_REG_CTRL      8'h00
`define VTC_REG_STATUS    8'h04
`define VTC_REG_VLAN_SEL  8'h08
`define VTC_REG_VLAN_MEMB 8'h0c
`define VTC_REG_RT_SEL    8'h10
`define VTC_REG_RT_NET    8'h14
`define VTC_REG_RT_MASK   8'h18
`define VTC_REG_RT_VIF    8'h1c
`define VTC_REG_VIF_SEL   8'h20
`define VTC_REG_VIF_VLAN  8'h24
`define VTC_REG_PORT_DEFAULT_VLAN_ID_BASE 3'h2

// field positions
`define VTC_CTRL_MULTI    0
`define VTC_STAT_REFUSED  16
`define VTC_STAT_INIT     17
`define VTC_RT_VALID      31

`endif

// *** vtc_pkg.sv ***
// vtc_pkg.sv: types shared by the vlan tag classifier modules.
// assumes: nothing beyond a standard compile order.
package vtc_pkg;
  typedef logic [11:0] vtc_vid_t;
  typedef logic [7:0]  vtc_mask_t;
  typedef logic [47:0] vtc_mac_t;
  typedef logic [2:0]  vtc_port_t;
  typedef logic [3:0]  vtc_idx_t;
  typedef enum logic [1:0] {
    VTC_ST_INIT = 2'b01,
    VTC_ST_RUN  = 2'b10
  } vtc_state_e;
endpackage : vtc_pkg

// *** vtc_mac_table.sv ***
// vtc_mac_table.sv: small learned table of mac, vlan and port.
// assumes: learn and lookup come from the same clock domain.
`timescale 1ns/10ps
`include "vtc_consts.svh"
module vtc_mac_table
  import vtc_pkg::*;
(
  // clock and control
  input  wire logic      core_clk,
  input  wire logic      rst,
  input  wire logic      ce,
  // learning side
  input  wire logic      learnEn,
  input  wire vtc_mac_t  learnMac,
  input  wire vtc_vid_t  learnVid,
  input  wire vtc_port_t learnPort,
  // lookup side
  input  wire vtc_mac_t  lookMac,
  input  wire vtc_vid_t  lookVid,
  output logic           lookHit,
  output vtc_port_t      lookPort
);
  vtc_mac_t  macTab  [`VTC_MAC_ENTRIES];
  vtc_vid_t  vidTab  [`VTC_MAC_ENTRIES];
  vtc_port_t portTab [`VTC_MAC_ENTRIES];
  logic [`VTC_MAC_ENTRIES-1:0] valid_ff;
  vtc_idx_t  repl_ff;
  logic      lrnHit;
  vtc_idx_t  lrnIdx;
  vtc_idx_t  lkIdx;

  // first valid entry matching mac within the vlan
  function automatic logic [4:0] vtc_find(input vtc_mac_t m,
                                          input vtc_vid_t v);
    vtc_find = 5'h00;
    for (int i = `VTC_MAC_ENTRIES - 1; i >= 0; i--) begin
      if (valid_ff[i] && macTab[i] == m && vidTab[i] == v) begin
        vtc_find = {1'b1, 4'(i)};
      end
    end
  endfunction : vtc_find

  // both searches call the same vtc_find function, so each has its own matcher
  always_comb begin
    {lrnHit, lrnIdx} = vtc_find(learnMac, learnVid);
    {lookHit, lkIdx} = vtc_find(lookMac, lookVid);
    lookPort = portTab[lkIdx];
  end

  // a station that moves updates in place; new ones evict round robin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      valid_ff <= '0;
      repl_ff  <= 4'h0;
    end else if (ce && learnEn) begin
      valid_ff[lrnHit ? lrnIdx : repl_ff] <= 1'b1;
      if (!lrnHit) begin
        repl_ff <= repl_ff + 4'h1;
      end
    end
  end

  // entry contents, no reset needed behind valid bits
  always_ff @(posedge core_clk) begin
    if (ce && learnEn) begin
      macTab[lrnHit ? lrnIdx : repl_ff]  <= learnMac;
      vidTab[lrnHit ? lrnIdx : repl_ff]  <= learnVid;
      portTab[lrnHit ? lrnIdx : repl_ff] <= learnPort;
    end
  end
endmodule : vtc_mac_table

// *** vtc_classifier.sv ***
// vtc_classifier.sv: vlan classification, membership, learning,
// routing lookup and egress tag decision for an 8-port switch.
// assumes: requests come from core_clk logic, frames fully stored.
// Overview of operation
// - untagged frame takes receiving port default vlan
// - tagged frame uses vlan identifier from tag
// - after reset all ports untagged in vlan 1
// - port default vlan resets to 1, writable
// - forward first, then strip tag toward unaware
// - forward first, then insert default vlan tag (route vlan if routed)
// - at most 255 vlans configured at once
// - ports hold several vlans, tagged or untagged
// - multilayer mode: a port joins one vlan
// - learn source macs, forward known, flood unknown
// - gvrp join adds receiving port to vlan
// - gvrp join repeated to all other ports
// - only fully received frames are switched
// - no bridging across vlans, only routed
// - route entry: network, mask, virtual interface
// - several routes may share one interface
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "vtc_consts.svh"
module vtc_classifier
  import vtc_pkg::*;
(
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // stored frame request
  input  wire logic        reqValid,
  output logic             reqReady,
  input  wire vtc_port_t   reqPort,
  input  wire logic        reqTagged,
  input  wire logic [15:0] reqTci,
  input  wire vtc_mac_t    reqSrcMac,
  input  wire vtc_mac_t    reqDstMac,
  input  wire logic        reqToRouter,
  input  wire logic [31:0] reqDstIp,
  input  wire logic        reqGvrpJoin,
  input  wire vtc_vid_t    reqGvrpVid,
  // forwarding answer
  output logic             rspValid,
  output vtc_vid_t         rspVlan,
  output vtc_mask_t        rspFwdMask,
  output vtc_mask_t        rspInsMask,
  output vtc_mask_t        rspStripMask,
  output logic [31:0]      rspTagWord,
  output logic             rspGvrp
);
  // state and configuration
  vtc_state_e  state_ff;
  vtc_vid_t    initIdx_ff, vlanSel_ff;
  logic [15:0] vlanMem [`VTC_VLAN_DEPTH];
  vtc_vid_t    port_default_vlan_id_ff [`VTC_NPORTS];
  logic [12:0] portCnt_ff [`VTC_NPORTS];
  logic [8:0]  vlanCnt_ff;
  logic        multi_ff, refused_ff, busAck_ff;
  vtc_idx_t    rtSel_ff, vifSel_ff;
  logic [31:0] rtNet_ff [`VTC_ROUTES], rtMask_ff [`VTC_ROUTES];
  vtc_idx_t    rtVif_ff  [`VTC_ROUTES];
  logic [`VTC_ROUTES-1:0] rtValid_ff;
  vtc_vid_t    vifVlan_ff [`VTC_VIFS];
  // answer registers
  logic        rspValid_ff, rspGvrp_ff;
  vtc_vid_t    rspVlan_ff;
  vtc_mask_t   rspFwd_ff, rspIns_ff, rspStrip_ff;
  logic [31:0] rspTag_ff, rdData_ff;
  // combinational
  logic        busGo, wrAck, reqFire, inOk, rtHit, lookHit;
  logic        updEn, gvrpUpd, updOk, updGo;
  vtc_mask_t   portBit, portHas, outMemb, tagMask, nxt_fwd;
  vtc_vid_t    curPvid, inVid, outVid, rtVid, updVid;
  vtc_port_t   lookPort;
  logic [15:0] updOld, updNew;
  logic [31:0] nxt_rdData;
  // refuses a 256th vlan and, in multilayer mode, a second vlan
  function automatic logic vtc_upd_ok(input vtc_mask_t oldM, newM, hasM,
                                      input logic multi,
                                      input logic [8:0] cnt);
    logic grow;
    grow = (oldM == 8'h00) && (newM != 8'h00);
    vtc_upd_ok = !(grow && cnt == `VTC_MAX_VLANS) &&
                 !(multi && |(newM & ~oldM & hasM));
  endfunction : vtc_upd_ok
  // bus answers after one wait cycle; blocked during the init sweep
  assign busGo    = ce && (avs_read || avs_write) && !busAck_ff &&
                    state_ff == VTC_ST_RUN;
  assign wrAck    = busAck_ff && avs_write;
  assign avs_waitrequest = !busAck_ff;
  assign avs_readdata    = rdData_ff;
  // no request while the bus commits, so one memory write port suffices
  assign reqReady = ce && state_ff == VTC_ST_RUN && !busAck_ff;
  assign reqFire  = reqValid && reqReady;
  // ingress classification and routing lookup
  always_comb begin
    portBit = 8'h01 << reqPort;
    for (int p = 0; p < `VTC_NPORTS; p++) begin
      portHas[p] = portCnt_ff[p] != 13'h0000;
    end
    curPvid = port_default_vlan_id_ff[reqPort];
    inVid   = reqTagged ? reqTci[11:0] : curPvid;
    inOk    = |(vlanMem[inVid][7:0] & portBit);
    rtHit   = 1'b0;
    rtVid   = 12'h000;
    for (int r = `VTC_ROUTES - 1; r >= 0; r--) begin
      if (rtValid_ff[r] &&
          ((reqDstIp ^ rtNet_ff[r]) & rtMask_ff[r]) == 32'h0000_0000) begin
        rtHit = 1'b1;
        rtVid = vifVlan_ff[rtVif_ff[r]];
      end
    end
    outVid  = reqToRouter ? rtVid : inVid;
    outMemb = vlanMem[outVid][7:0];
    tagMask = outMemb & ~vlanMem[outVid][15:8];
  end
  // destination choice: known port, else flood inside the vlan
  always_comb begin
    if (reqGvrpJoin) begin
      nxt_fwd = updOk ? ~portBit : 8'h00;
    end else if (!inOk || (reqToRouter && !rtHit)) begin
      nxt_fwd = 8'h00;
    end else if (lookHit) begin
      nxt_fwd = (8'h01 << lookPort) & outMemb &
                (reqToRouter ? 8'hff : ~portBit);
    end else begin
      nxt_fwd = outMemb & (reqToRouter ? 8'hff : ~portBit);
    end
  end
  // one membership update path shared by software and gvrp
  always_comb begin
    gvrpUpd = reqFire && reqGvrpJoin;
    updEn   = gvrpUpd || (wrAck && avs_address == `VTC_REG_VLAN_MEMB);
    updVid  = gvrpUpd ? reqGvrpVid : vlanSel_ff;
    updOld  = vlanMem[updVid];
    if (gvrpUpd) begin
      updNew = {updOld[15:8], updOld[7:0] | portBit};
    end else begin
      updNew = {avs_writedata[15:8] & avs_writedata[7:0],
                avs_writedata[7:0]};
    end
    updOk = vtc_upd_ok(updOld[7:0], updNew[7:0], portHas, multi_ff,
                       vlanCnt_ff);
    updGo = updEn && updOk;
  end
  vtc_mac_table vtc_mac_table_inst (
    .core_clk  (core_clk),
    .rst       (rst),
    .ce        (ce),
    .learnEn   (reqFire && inOk && !reqGvrpJoin),
    .learnMac  (reqSrcMac),
    .learnVid  (inVid),
    .learnPort (reqPort),
    .lookMac   (reqDstMac),
    .lookVid   (outVid),
    .lookHit   (lookHit),
    .lookPort  (lookPort)
  );
  // init sweep then run; memory cannot be cleared by async reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff   <= VTC_ST_INIT;
      initIdx_ff <= 12'h000;
    end else if (ce && state_ff == VTC_ST_INIT) begin
      initIdx_ff <= initIdx_ff + 12'h001;
      if (initIdx_ff == `VTC_LAST_VID) begin
        state_ff <= VTC_ST_RUN;
      end
    end
  end
  // membership memory write port
  always_ff @(posedge core_clk) begin
    if (ce && state_ff == VTC_ST_INIT) begin
      vlanMem[initIdx_ff] <= (initIdx_ff == `VTC_RST_PORT_DEFAULT_VLAN_ID) ?
                             `VTC_RST_MEMB : 16'h0000;
    end else if (ce && updGo) begin
      vlanMem[updVid] <= updNew;
    end
  end
  // per-port and global membership counts follow every update
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vlanCnt_ff <= 9'h001;
      for (int p = 0; p < `VTC_NPORTS; p++) begin
        portCnt_ff[p] <= 13'h0001;
      end
    end else if (ce && updGo) begin
      if (updOld[7:0] == 8'h00 && updNew[7:0] != 8'h00) begin
        vlanCnt_ff <= vlanCnt_ff + 9'h001;
      end else if (updOld[7:0] != 8'h00 && updNew[7:0] == 8'h00) begin
        vlanCnt_ff <= vlanCnt_ff - 9'h001;
      end
      for (int p = 0; p < `VTC_NPORTS; p++) begin
        if (updNew[p] && !updOld[p]) begin
          portCnt_ff[p] <= portCnt_ff[p] + 13'h0001;
        end else if (!updNew[p] && updOld[p]) begin
          portCnt_ff[p] <= portCnt_ff[p] - 13'h0001;
        end
      end
    end
  end
  // software registers; a refused update sets a sticky flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      multi_ff   <= 1'b0;
      refused_ff <= 1'b0;
      vlanSel_ff <= 12'h000;
      rtSel_ff   <= 4'h0;
      vifSel_ff  <= 4'h0;
      rtValid_ff <= '0;
      for (int p = 0; p < `VTC_NPORTS; p++) begin
        port_default_vlan_id_ff[p] <= `VTC_RST_PORT_DEFAULT_VLAN_ID;
      end
    end else if (ce) begin
      // set wins over the write-one clear
      if (updEn && !updOk) begin
        refused_ff <= 1'b1;
      end else if (wrAck && avs_address == `VTC_REG_STATUS &&
                   avs_writedata[`VTC_STAT_REFUSED]) begin
        refused_ff <= 1'b0;
      end
      if (wrAck) begin
        case (avs_address)
          `VTC_REG_CTRL:     multi_ff   <= avs_writedata[`VTC_CTRL_MULTI];
          `VTC_REG_VLAN_SEL: vlanSel_ff <= avs_writedata[11:0];
          `VTC_REG_RT_SEL:   rtSel_ff   <= avs_writedata[3:0];
          `VTC_REG_VIF_SEL:  vifSel_ff  <= avs_writedata[3:0];
          `VTC_REG_RT_VIF:   rtValid_ff[rtSel_ff] <=
                               avs_writedata[`VTC_RT_VALID];
          default: begin
            if (avs_address[7:5] == `VTC_REG_PORT_DEFAULT_VLAN_ID_BASE) begin
              port_default_vlan_id_ff[avs_address[4:2]] <= avs_writedata[11:0];
            end
          end
        endcase
      end
    end
  end
  // route and interface tables; routes guarded by valid bits
  always_ff @(posedge core_clk) begin
    if (ce && wrAck) begin
      case (avs_address)
        `VTC_REG_RT_NET:   rtNet_ff[rtSel_ff]    <= avs_writedata;
        `VTC_REG_RT_MASK:  rtMask_ff[rtSel_ff]   <= avs_writedata;
        `VTC_REG_RT_VIF:   rtVif_ff[rtSel_ff]    <= avs_writedata[3:0];
        `VTC_REG_VIF_VLAN: vifVlan_ff[vifSel_ff] <= avs_writedata[11:0];
        default: ;
      endcase
    end
  end
  // read mux; unmapped addresses read as zero
  always_comb begin
    nxt_rdData = 32'h0000_0000;
    case (avs_address)
      `VTC_REG_CTRL:      nxt_rdData[`VTC_CTRL_MULTI] = multi_ff;
      `VTC_REG_STATUS:    nxt_rdData = {15'h0, refused_ff, 7'h0, vlanCnt_ff};
      `VTC_REG_VLAN_SEL:  nxt_rdData[11:0] = vlanSel_ff;
      `VTC_REG_VLAN_MEMB: nxt_rdData[15:0] = vlanMem[vlanSel_ff];
      `VTC_REG_RT_SEL:    nxt_rdData[3:0]  = rtSel_ff;
      `VTC_REG_RT_NET:    nxt_rdData = rtNet_ff[rtSel_ff];
      `VTC_REG_RT_MASK:   nxt_rdData = rtMask_ff[rtSel_ff];
      `VTC_REG_RT_VIF:    nxt_rdData = {rtValid_ff[rtSel_ff], 27'h000_0000,
                                        rtVif_ff[rtSel_ff]};
      `VTC_REG_VIF_SEL:   nxt_rdData[3:0]  = vifSel_ff;
      `VTC_REG_VIF_VLAN:  nxt_rdData[11:0] = vifVlan_ff[vifSel_ff];
      default: begin
        if (avs_address[7:5] == `VTC_REG_PORT_DEFAULT_VLAN_ID_BASE) begin
          nxt_rdData[11:0] = port_default_vlan_id_ff[avs_address[4:2]];
        end
      end
    endcase
  end
  // bus handshake and read data
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busAck_ff <= 1'b0;
      rdData_ff <= 32'h0000_0000;
    end else if (ce) begin
      busAck_ff <= busGo;
      if (busGo && avs_read) begin
        rdData_ff <= nxt_rdData;
      end
    end
  end
  // answer one cycle after the request is taken
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rspValid_ff <= 1'b0;
      rspVlan_ff  <= 12'h000;
      rspFwd_ff   <= 8'h00;
      rspIns_ff   <= 8'h00;
      rspStrip_ff <= 8'h00;
      rspTag_ff   <= 32'h0000_0000;
      rspGvrp_ff  <= 1'b0;
    end else if (ce) begin
      rspValid_ff <= reqFire;
      if (reqFire) begin
        rspVlan_ff  <= reqGvrpJoin ? reqGvrpVid : outVid;
        rspFwd_ff   <= nxt_fwd;
        rspGvrp_ff  <= reqGvrpJoin;
        // join frames leave unchanged; tags follow the egress port
        rspIns_ff   <= reqGvrpJoin ? 8'h00 :
                       nxt_fwd & tagMask & {8{!reqTagged}};
        rspStrip_ff <= reqGvrpJoin ? 8'h00 :
                       nxt_fwd & ~tagMask & {8{reqTagged}};
        rspTag_ff   <= {`VTC_TPID, reqTagged ? reqTci[15:12] : 4'h0,
                        outVid};
      end
    end
  end
  assign rspValid     = rspValid_ff;
  assign rspVlan      = rspVlan_ff;
  assign rspFwdMask   = rspFwd_ff;
  assign rspInsMask   = rspIns_ff;
  assign rspStripMask = rspStrip_ff;
  assign rspTagWord   = rspTag_ff;
  assign rspGvrp      = rspGvrp_ff;
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_untag_port_default_vlan_id: assert property (
    reqFire && !reqTagged && !reqGvrpJoin && !reqToRouter
    |=> rspVlan == $past(curPvid))
    else $error("untagged frame not in port default vlan");
  a_tag_vid: assert property (
    reqFire && reqTagged && !reqGvrpJoin && !reqToRouter
    |=> rspVlan == $past(reqTci[11:0]))
    else $error("tagged frame not in tag vlan");
  a_init_vlan1: assert property (
    $rose(state_ff == VTC_ST_RUN)
    |-> vlanMem[`VTC_RST_PORT_DEFAULT_VLAN_ID] == `VTC_RST_MEMB && vlanCnt_ff == 9'h001)
    else $error("vlan 1 not set after init");
  a_port_default_vlan_id_reset: assert property (
    state_ff == VTC_ST_INIT && initIdx_ff == 12'h000
    |-> port_default_vlan_id_ff[0] == `VTC_RST_PORT_DEFAULT_VLAN_ID && port_default_vlan_id_ff[7] == `VTC_RST_PORT_DEFAULT_VLAN_ID)
    else $error("default vlan not 1 after reset");
  a_strip_fwd: assert property (
    rspValid |-> (rspStripMask & ~rspFwdMask) == 8'h00 &&
                 (rspStripMask & rspInsMask) == 8'h00)
    else $error("strip outside forwarded ports");
  a_insert_tag: assert property (
    rspValid && rspInsMask != 8'h00
    |-> rspTagWord[11:0] == rspVlan && rspTagWord[31:16] == `VTC_TPID)
    else $error("inserted tag malformed");
  a_vlan_limit: assert property (
    vlanCnt_ff <= `VTC_MAX_VLANS)
    else $error("too many vlans");
  a_multi_one: assert property (
    multi_ff && updEn && |(updNew[7:0] & ~updOld[7:0] & portHas)
    |-> !updGo ##1 refused_ff)
    else $error("second vlan accepted in multilayer mode");
  a_gvrp_flood: assert property (
    gvrpUpd && updOk |=> rspGvrp && rspFwdMask == ~$past(portBit))
    else $error("join not sent to all other ports");
  a_no_bridge: assert property (
    rspValid && !rspGvrp
    |-> (rspFwdMask & ~vlanMem[rspVlan][7:0]) == 8'h00)
    else $error("frame sent outside its vlan");
  a_no_init_req: assert property (
    state_ff == VTC_ST_INIT |-> !reqReady && avs_waitrequest)
    else $error("request taken during init");
endmodule : vtc_classifier

// *** vtc_frame_source.sv ***
// vtc_frame_source.sv: stand-in for the frame store in front of the
// classifier; offers one stored frame summary at a time.
// assumes: tasks are entered just after a rising core_clk edge.
`timescale 1ns/10ps
module vtc_frame_source
  import vtc_pkg::*;
(
  // clock and handshake
  input  wire logic   core_clk,
  input  wire logic   reqReady,
  output logic        reqValid,
  // frame summary
  output vtc_port_t   reqPort,
  output logic        reqTagged,
  output logic [15:0] reqTci,
  output vtc_mac_t    reqSrcMac,
  output vtc_mac_t    reqDstMac,
  output logic        reqGvrpJoin,
  output vtc_vid_t    reqGvrpVid
);
  // idle values at time zero
  initial begin
    reqValid    = 1'b0;
    reqPort     = 3'h0;
    reqTagged   = 1'b0;
    reqTci      = 16'h0000;
    reqSrcMac   = 48'h0000_0000_0000;
    reqDstMac   = 48'h0000_0000_0000;
    reqGvrpJoin = 1'b0;
    reqGvrpVid  = 12'h000;
  end

  // offer a frame only once it is wholly stored, hold until taken
  task automatic send(input vtc_port_t p, input logic tg,
                      input logic [15:0] tci, input vtc_mac_t s,
                      input vtc_mac_t d, input logic gj,
                      input vtc_vid_t gv);
    reqValid    <= 1'b1;
    reqPort     <= p;
    reqTagged   <= tg;
    reqTci      <= tci;
    reqSrcMac   <= s;
    reqDstMac   <= d;
    reqGvrpJoin <= gj;
    reqGvrpVid  <= gv;
    do @(posedge core_clk); while (reqReady !== 1'b1);
    // stale tci and dst mac flipped so nothing leans on old values
    reqValid <= 1'b0;
    reqTci   <= ~tci;
    reqDstMac <= ~d;
  endtask : send
endmodule : vtc_frame_source

// *** vtc_classifier_tb_top.sv ***
// vtc_classifier_tb_top.sv: self-checking bench for vtc_classifier.
// assumes: 200 MHz core_clk, async active-high rst, 4096-cycle sweep.
`timescale 1ns/10ps
`include "vtc_consts.svh"
module vtc_classifier_tb_top
  import vtc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic reqToRouter = 1'b0;
  logic [31:0] reqDstIp = 32'h0000_0000;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, reqValid, reqReady, reqTagged, reqGvrpJoin;
  logic rspValid, rspGvrp;
  logic [15:0] reqTci;
  logic [31:0] rspTagWord, rdWord;
  vtc_port_t reqPort;
  vtc_mac_t reqSrcMac, reqDstMac;
  vtc_vid_t reqGvrpVid, rspVlan;
  vtc_mask_t rspFwdMask, rspInsMask, rspStripMask;
  int miscompares = 0;
  int nCompared = 0;
  int cycles = 0;

  // clock: 5 ns period
  always #2.5 core_clk = ~core_clk;

  vtc_frame_source vtc_frame_source_inst (.core_clk(core_clk),
    .reqReady(reqReady), .reqValid(reqValid), .reqPort(reqPort),
    .reqTagged(reqTagged), .reqTci(reqTci), .reqSrcMac(reqSrcMac),
    .reqDstMac(reqDstMac), .reqGvrpJoin(reqGvrpJoin),
    .reqGvrpVid(reqGvrpVid));

  vtc_classifier vtc_classifier_inst (.core_clk(core_clk), .rst(rst),
    .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .reqValid(reqValid), .reqReady(reqReady), .reqPort(reqPort),
    .reqTagged(reqTagged), .reqTci(reqTci), .reqSrcMac(reqSrcMac),
    .reqDstMac(reqDstMac), .reqToRouter(reqToRouter),
    .reqDstIp(reqDstIp), .reqGvrpJoin(reqGvrpJoin),
    .reqGvrpVid(reqGvrpVid), .rspValid(rspValid), .rspVlan(rspVlan),
    .rspFwdMask(rspFwdMask), .rspInsMask(rspInsMask),
    .rspStripMask(rspStripMask), .rspTagWord(rspTagWord),
    .rspGvrp(rspGvrp));

  task automatic tally_and_finish();
    if (miscompares == 0 && nCompared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard: sweep plus about 5900 cycles of transfers
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one avalon access; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rdWord = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  // one frame; answer is judged the cycle after it is taken
  task automatic frame(input vtc_port_t p, input logic tg,
      input logic [15:0] tci, input vtc_mac_t s, input vtc_mac_t d,
      input logic gj, input vtc_vid_t ev, input vtc_mask_t ef,
      input vtc_mask_t ei, input vtc_mask_t es);
    vtc_frame_source_inst.send(p, tg, tci, s, d, gj, tci[11:0]);
    @(posedge core_clk);
    chk("rspValid", 32'h1, {31'h0, rspValid});
    chk("rspGvrp", {31'h0, gj}, {31'h0, rspGvrp});
    chk("rspVlan", {20'h0, ev}, {20'h0, rspVlan});
    chk("rspFwdMask", {24'h0, ef}, {24'h0, rspFwdMask});
    chk("rspInsMask", {24'h0, ei}, {24'h0, rspInsMask});
    chk("rspStripMask", {24'h0, es}, {24'h0, rspStripMask});
  endtask : frame

  // defaults after the sweep, plus an unmapped read
  task automatic t_reset_state();
    bus(1'b0, `VTC_REG_STATUS, 32'h0);
    chk("vlan count", 32'h0000_0001, rdWord);
    bus(1'b0, 8'h4c, 32'h0);
    chk("port3 default", 32'h0000_0001, rdWord);
    bus(1'b1, `VTC_REG_VLAN_SEL, 32'h0000_0001);
    bus(1'b0, `VTC_REG_VLAN_MEMB, 32'h0);
    chk("vlan1 members", 32'h0000_ffff, rdWord);
    bus(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'h0000_0000, rdWord);
  endtask : t_reset_state

  task automatic t_untagged_default();
    frame(3'h2, 1'b0, 16'h0000, 48'h0a, 48'h0e, 1'b0,
          12'h001, 8'hfb, 8'h00, 8'h00);
  endtask : t_untagged_default

  // vlan 5 = ports 3,4,5, only port 3 untagged; port 3 default 5
  task automatic t_tag_edges();
    bus(1'b1, `VTC_REG_VLAN_SEL, 32'h0000_0005);
    bus(1'b1, `VTC_REG_VLAN_MEMB, 32'h0000_0838);
    bus(1'b1, 8'h4c, 32'h0000_0005);
    frame(3'h3, 1'b0, 16'h0000, 48'h03, 48'h0e, 1'b0,
          12'h005, 8'h30, 8'h30, 8'h00);
    chk("tag word", 32'h8100_0005, rspTagWord);
    frame(3'h4, 1'b1, 16'h6005, 48'h04, 48'h0e, 1'b0,
          12'h005, 8'h28, 8'h00, 8'h08);
    chk("tag word", 32'h8100_6005, rspTagWord);
    frame(3'h3, 1'b0, 16'h0000, 48'h03, 48'h04, 1'b0,
          12'h005, 8'h10, 8'h10, 8'h00);
    frame(3'h0, 1'b1, 16'h0005, 48'h05, 48'h04, 1'b0,
          12'h005, 8'h00, 8'h00, 8'h00);
  endtask : t_tag_edges

  task automatic t_gvrp_join();
    frame(3'h6, 1'b0, 16'h0005, 48'h06, 48'h0e, 1'b1,
          12'h005, 8'hbf, 8'h00, 8'h00);
    bus(1'b0, `VTC_REG_VLAN_MEMB, 32'h0);
    chk("vlan5 members", 32'h0000_0878, rdWord);
  endtask : t_gvrp_join

  // routes 0 and 1 share interface 2 (vlan 5); a miss goes nowhere
  task automatic t_route();
    bus(1'b1, `VTC_REG_VIF_SEL, 32'h0000_0002);
    bus(1'b1, `VTC_REG_VIF_VLAN, 32'h0000_0005);
    bus(1'b1, `VTC_REG_RT_SEL, 32'h0000_0000);
    bus(1'b1, `VTC_REG_RT_NET, 32'h0a00_0000);
    bus(1'b1, `VTC_REG_RT_MASK, 32'hff00_0000);
    bus(1'b1, `VTC_REG_RT_VIF, 32'h8000_0002);
    bus(1'b1, `VTC_REG_RT_SEL, 32'h0000_0001);
    bus(1'b1, `VTC_REG_RT_NET, 32'h0b00_0000);
    bus(1'b1, `VTC_REG_RT_MASK, 32'hff00_0000);
    bus(1'b1, `VTC_REG_RT_VIF, 32'h8000_0002);
    bus(1'b0, `VTC_REG_RT_VIF, 32'h0);
    chk("route 1 vif", 32'h8000_0002, rdWord);
    reqToRouter <= 1'b1;
    reqDstIp    <= 32'h0a01_0203;
    frame(3'h2, 1'b0, 16'h0000, 48'h02, 48'h04, 1'b0,
          12'h005, 8'h10, 8'h10, 8'h00);
    reqDstIp    <= 32'h0b01_0203;
    frame(3'h2, 1'b0, 16'h0000, 48'h02, 48'h04, 1'b0,
          12'h005, 8'h10, 8'h10, 8'h00);
    reqDstIp    <= 32'h0c01_0203;
    frame(3'h2, 1'b0, 16'h0000, 48'h02, 48'h04, 1'b0,
          12'h000, 8'h00, 8'h00, 8'h00);
    reqToRouter <= 1'b0;
  endtask : t_route

  // port 6 already in two vlans, so a third join is refused
  task automatic t_multilayer();
    bus(1'b1, `VTC_REG_CTRL, 32'h0000_0001);
    frame(3'h6, 1'b0, 16'h0009, 48'h06, 48'h0e, 1'b1,
          12'h009, 8'h00, 8'h00, 8'h00);
    bus(1'b0, `VTC_REG_STATUS, 32'h0);
    chk("status", 32'h0001_0002, rdWord);
    bus(1'b1, `VTC_REG_STATUS, 32'h0001_0000);
    bus(1'b0, `VTC_REG_STATUS, 32'h0);
    chk("status", 32'h0000_0002, rdWord);
  endtask : t_multilayer

  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    do @(posedge core_clk); while (reqReady !== 1'b1);
    t_reset_state();
    t_untagged_default();
    t_tag_edges();
    t_gvrp_join();
    t_route();
    t_multilayer();
    tally_and_finish();
  end
endmodule : vtc_classifier_tb_top
